// ---- src/dio16_edge_interrupt_timestamp.sv ----
// 16-channel input side: filter, edge flags, process interrupts, timestamps
`default_nettype none
// Function
// - basic mode: two input and two output bytes, parameter writes refused
// - without a configuration load the block stays in basic mode
// - basic mode input delay is a fixed 2.56 us
// - alarm mode: 48 input bytes, 2 output bytes, 66 parameter bytes
// - alarm mode delay is 1 us plus the channel filter time
// - diag, selection and filter records are accepted and applied at runtime
// - diag word zero equal to one enables diagnostics, zero disables; next word reserved
// - retrigger while a channel interrupt is still pending raises the diagnostic interrupt
// - edge select bits 1:0 choose interrupt on none, rising, falling, both
// - parameter bytes 16 to 31 choose timestamp edge with same coding
// - free running 1 us timer starts at controller boot
// - selected edge copies timer into the channel timestamp slot
// - timestamp taken on the filtered signal, not the raw pin
// - activity lamp lit when input reads one or output is driven
// - common error lamp lit on any output overload or short
// - filter count of 2.56 us units, limited to 1 through 16000
// - edge flag set on an edge, cleared by the controller reading it
// - edge lost set on a further edge before the flag was read
// - only the low 16 timer bits are stored
module dio16_edge_interrupt_timestamp #(
    parameter int CH = dio_edge_pkg::CHANNELS
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    // controller configuration and timebase
    input  wire logic          cfgLoad,
    input  wire logic          cfgAlarm,
    input  wire logic          ctrlBoot,
    // parameter record writes
    input  wire logic          prmWrite,
    input  wire logic [7:0]    prmRecord,
    input  wire logic [6:0]    prmIndex,
    input  wire logic [7:0]    prmData,
    output logic               prmErr,
    // input process image reads
    input  wire logic          piiRead,
    input  wire logic [5:0]    piiAddr,
    output logic [7:0]         piiData,
    output logic               piiReadErr,
    // output process image writes
    input  wire logic          piqWrite,
    input  wire logic          piqAddr,
    input  wire logic [7:0]    piqData,
    // interrupts and acknowledge
    input  wire logic          irqAck,
    input  wire logic [3:0]    irqAckChannel,
    output logic [CH-1:0]      procIrq,
    output logic               diagIrq,
    // pins and lamps
    input  wire logic [CH-1:0] inPins,
    input  wire logic [CH-1:0] faultIn,
    output logic [CH-1:0]      outDrive,
    output logic [CH-1:0]      activityLed,
    output logic               errorLed,
    output logic               alarmMode
);
    localparam logic [6:0] PRE_LAST = 7'(dio_edge_pkg::TIMER_STEP_CYC - 1);

    // read of a byte pair clears the matching half of a 16-bit flag set
    function automatic logic [15:0] pairMask(input logic rd, input logic [5:0] a, input logic [5:0] base);
        return {(rd && a == base + 6'h01) ? 8'hFF : 8'h00, (rd && a == base) ? 8'hFF : 8'h00};
    endfunction

    dio_edge_pkg::mode_t mode_reg, mode_next;
    logic [15:0]         diagWord_reg, diagWord_next;
    dio_edge_pkg::sel_t  edgeSel_reg [CH];
    dio_edge_pkg::sel_t  edgeSel_next [CH];
    dio_edge_pkg::sel_t  tsSel_reg [CH];
    dio_edge_pkg::sel_t  tsSel_next [CH];
    logic [15:0]         filterWord_reg [CH];
    logic [15:0]         filterWord_next [CH];
    logic                prmErr_reg, prmErr_next;
    logic                accept, bad, diagEn, alarm;

    assign alarm  = mode_reg == dio_edge_pkg::MODE_ALARM;
    assign diagEn = diagWord_reg == dio_edge_pkg::DIAG_ON;

    always_comb begin
        mode_next = mode_reg;
        if (cfgLoad) mode_next = cfgAlarm ? dio_edge_pkg::MODE_ALARM : dio_edge_pkg::MODE_BASIC;
        diagWord_next   = diagWord_reg;
        edgeSel_next    = edgeSel_reg;
        tsSel_next      = tsSel_reg;
        filterWord_next = filterWord_reg;
        accept = prmWrite && alarm;
        bad = 1'b0;
        if (accept) begin
            unique case (prmRecord)
                dio_edge_pkg::REC_DIAG: begin
                    if (prmIndex == dio_edge_pkg::DIAG_WORD_HI) diagWord_next[15:8] = prmData;
                    else if (prmIndex == dio_edge_pkg::DIAG_WORD_LO) diagWord_next[7:0] = prmData;
                    else if (prmIndex > 7'h03) bad = 1'b1;
                end
                dio_edge_pkg::REC_SELECT: begin
                    // bits 7:2 are dropped on write
                    if (prmIndex <= dio_edge_pkg::EDGE_SEL_LAST)
                        edgeSel_next[prmIndex[3:0]] = dio_edge_pkg::sel_t'(prmData[1:0]);
                    else if (prmIndex <= dio_edge_pkg::TS_SEL_LAST)
                        tsSel_next[prmIndex[3:0]] = dio_edge_pkg::sel_t'(prmData[1:0]);
                    else bad = 1'b1;
                end
                dio_edge_pkg::REC_FILTER: begin
                    if (prmIndex > dio_edge_pkg::FILTER_LAST) bad = 1'b1;
                    else if (prmIndex[0]) filterWord_next[prmIndex[4:1]][7:0] = prmData;
                    else filterWord_next[prmIndex[4:1]][15:8] = prmData;
                end
                default: bad = 1'b1;
            endcase
        end
        prmErr_next = (prmWrite && !alarm) || bad;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_reg     <= dio_edge_pkg::MODE_BASIC;
            diagWord_reg <= 16'h0000;
            prmErr_reg   <= 1'b0;
            for (int i = 0; i < CH; i++) begin
                edgeSel_reg[i]    <= dio_edge_pkg::SEL_OFF;
                tsSel_reg[i]      <= dio_edge_pkg::SEL_OFF;
                filterWord_reg[i] <= dio_edge_pkg::FILTER_MIN;
            end
        end else begin
            mode_reg       <= mode_next;
            diagWord_reg   <= diagWord_next;
            prmErr_reg     <= prmErr_next;
            edgeSel_reg    <= edgeSel_next;
            tsSel_reg      <= tsSel_next;
            filterWord_reg <= filterWord_next;
        end
    end

    // synchroniser and filter per channel
    logic [CH-1:0] syncA_reg, syncB_reg, filt;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= inPins;
            syncB_reg <= syncA_reg;
        end
    end

    generate
        for (genvar g = 0; g < CH; g++) begin : gen_chan
            input_filter u_filter (
                .mclk        (mclk),
                .sys_rst     (sys_rst),
                .sampleIn    (syncB_reg[g]),
                .alarmMode   (alarm),
                .filterUnits (filterWord_reg[g]),
                .filtered    (filt[g])
            );
        end
    endgenerate

    // microsecond timebase; held at zero until the controller boots
    logic        run_reg, run_next;
    logic [6:0]  pre_reg, pre_next;
    logic [15:0] usTimer_reg, usTimer_next;
    always_comb begin
        run_next     = run_reg;
        pre_next     = pre_reg;
        usTimer_next = usTimer_reg;
        if (ctrlBoot) begin
            run_next     = 1'b1;
            pre_next     = 7'h00;
            usTimer_next = 16'h0000;
        end else if (run_reg) begin
            if (pre_reg == PRE_LAST) begin
                pre_next     = 7'h00;
                usTimer_next = usTimer_reg + 16'h0001;
            end else begin
                pre_next = pre_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            run_reg     <= 1'b0;
            pre_reg     <= 7'h00;
            usTimer_reg <= 16'h0000;
        end else begin
            run_reg     <= run_next;
            pre_reg     <= pre_next;
            usTimer_reg <= usTimer_next;
        end
    end

    // edge evaluation, interrupts, timestamps
    logic [CH-1:0] prev_reg, rise, fall, anyEdge, trig, clrE, clrL, ackMask;
    logic [CH-1:0] edgeFlag_reg, edgeFlag_next, edgeLost_reg, edgeLost_next;
    logic [CH-1:0] pending_reg, pending_next;
    logic          diagIrq_reg, diagIrq_next;
    logic [15:0]   ts_reg [CH];
    logic [15:0]   ts_next [CH];

    assign clrE    = pairMask(piiRead && alarm, piiAddr, dio_edge_pkg::PII_EDGE);
    assign clrL    = pairMask(piiRead && alarm, piiAddr, dio_edge_pkg::PII_LOST);
    assign ackMask = irqAck ? (CH'(1) << irqAckChannel) : '0;

    always_comb begin
        ts_next = ts_reg;
        for (int i = 0; i < CH; i++) begin
            rise[i]    = filt[i] && !prev_reg[i];
            fall[i]    = !filt[i] && prev_reg[i];
            anyEdge[i] = alarm && (rise[i] || fall[i]);
            trig[i]    = alarm && dio_edge_pkg::selHit(edgeSel_reg[i], rise[i], fall[i]);
            if (alarm && dio_edge_pkg::selHit(tsSel_reg[i], rise[i], fall[i]))
                ts_next[i] = usTimer_reg;
        end
        // a new event wins over a clear landing in the same cycle
        edgeFlag_next = anyEdge | (edgeFlag_reg & ~clrE);
        edgeLost_next = (anyEdge & edgeFlag_reg & ~clrE) | (edgeLost_reg & ~clrL);
        pending_next  = trig | (pending_reg & ~ackMask);
        diagIrq_next  = diagEn && |(trig & pending_reg);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prev_reg     <= '0;
            edgeFlag_reg <= '0;
            edgeLost_reg <= '0;
            pending_reg  <= '0;
            diagIrq_reg  <= 1'b0;
            for (int i = 0; i < CH; i++) ts_reg[i] <= 16'h0000;
        end else begin
            prev_reg     <= filt;
            edgeFlag_reg <= edgeFlag_next;
            edgeLost_reg <= edgeLost_next;
            pending_reg  <= pending_next;
            diagIrq_reg  <= diagIrq_next;
            ts_reg       <= ts_next;
        end
    end

    // process image read port, output image and lamps
    logic [7:0]    piiData_reg, piiData_next;
    logic          piiErr_reg, piiErr_next;
    logic [CH-1:0] outDrive_reg, outDrive_next, actLed_reg, actLed_next;
    logic          errLed_reg;
    logic [6:0]    piiLimit;
    logic [5:0]    tsOff;
    logic [15:0]   tsWord;

    always_comb begin
        piiLimit     = alarm ? dio_edge_pkg::ALARM_IN_BYTES : dio_edge_pkg::BASIC_IN_BYTES;
        tsOff        = piiAddr - dio_edge_pkg::PII_TS;
        tsWord       = ts_reg[{tsOff[4:2], tsOff[1]}];
        piiData_next = 8'h00;
        piiErr_next  = 1'b0;
        if (piiRead) begin
            if ({1'b0, piiAddr} >= piiLimit) piiErr_next = 1'b1;
            else if (piiAddr == dio_edge_pkg::PII_STATE) piiData_next = filt[7:0];
            else if (piiAddr == dio_edge_pkg::PII_STATE + 6'h01) piiData_next = filt[15:8];
            else if (piiAddr == dio_edge_pkg::PII_EDGE) piiData_next = edgeFlag_reg[7:0];
            else if (piiAddr == dio_edge_pkg::PII_EDGE + 6'h01) piiData_next = edgeFlag_reg[15:8];
            else if (piiAddr == dio_edge_pkg::PII_LOST) piiData_next = edgeLost_reg[7:0];
            else if (piiAddr == dio_edge_pkg::PII_LOST + 6'h01) piiData_next = edgeLost_reg[15:8];
            else if (piiAddr >= dio_edge_pkg::PII_TS && piiAddr <= dio_edge_pkg::PII_TS_END)
                piiData_next = tsOff[0] ? tsWord[7:0] : tsWord[15:8];
        end
        outDrive_next = outDrive_reg;
        if (piqWrite && !piqAddr) outDrive_next[7:0] = piqData;
        if (piqWrite && piqAddr) outDrive_next[15:8] = piqData;
        actLed_next = filt | outDrive_reg;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            piiData_reg  <= 8'h00;
            piiErr_reg   <= 1'b0;
            outDrive_reg <= '0;
            actLed_reg   <= '0;
            errLed_reg   <= 1'b0;
        end else begin
            piiData_reg  <= piiData_next;
            piiErr_reg   <= piiErr_next;
            outDrive_reg <= outDrive_next;
            actLed_reg   <= actLed_next;
            errLed_reg   <= |faultIn;
        end
    end

    assign piiData     = piiData_reg;
    assign piiReadErr  = piiErr_reg;
    assign prmErr      = prmErr_reg;
    assign procIrq     = pending_reg;
    assign diagIrq     = diagIrq_reg;
    assign outDrive    = outDrive_reg;
    assign activityLed = actLed_reg;
    assign errorLed    = errLed_reg;
    assign alarmMode   = mode_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_busyRetrigger;
        diagEn && trig[0] && pending_reg[0];
    endsequence
    sequence s_secondEdge;
        anyEdge[0] && edgeFlag_reg[0] && !clrE[0];
    endsequence

    property p_basic_prm;
        prmWrite && !alarm && !cfgLoad |=> prmErr && $stable(diagWord_reg);
    endproperty
    a_basic_prm: assert property (p_basic_prm) else $error("basic mode took parameter data");
    property p_basic_range;
        piiRead && !alarm && piiAddr >= 6'h02 |=> piiReadErr && piiData == 8'h00;
    endproperty
    a_basic_range: assert property (p_basic_range) else $error("basic mode read beyond two bytes");
    property p_cfg_basic;
        cfgLoad && !cfgAlarm |=> !alarmMode;
    endproperty
    a_cfg_basic: assert property (p_cfg_basic) else $error("basic configuration not taken");
    property p_alarm_range;
        piiRead && alarm && piiAddr >= 6'h30 |=> piiReadErr;
    endproperty
    a_alarm_range: assert property (p_alarm_range) else $error("read beyond 48 bytes accepted");
    property p_diag_off;
        !diagEn |=> !diagIrq;
    endproperty
    a_diag_off: assert property (p_diag_off) else $error("diagnostic raised while disabled");
    property p_diag;
        s_busyRetrigger |=> diagIrq;
    endproperty
    a_diag: assert property (p_diag) else $error("retrigger gave no diagnostic");
    property p_pi_rise;
        alarm && rise[0] && edgeSel_reg[0] == dio_edge_pkg::SEL_RISE |=> procIrq[0] ##1 procIrq[0] || $past(irqAck);
    endproperty
    a_pi_rise: assert property (p_pi_rise) else $error("rising edge raised no interrupt");
    property p_ts;
        alarm && fall[0] && tsSel_reg[0][1] |=> ts_reg[0] == $past(usTimer_reg);
    endproperty
    a_ts: assert property (p_ts) else $error("timestamp not captured");
    property p_timer;
        run_reg && !ctrlBoot && pre_reg == PRE_LAST |=> usTimer_reg == $past(usTimer_reg) + 16'h0001;
    endproperty
    a_timer: assert property (p_timer) else $error("timer missed a microsecond step");
    property p_timer_hold;
        !ctrlBoot && pre_reg != PRE_LAST |=> $stable(usTimer_reg);
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer stepped early");
    property p_flag_clear;
        piiRead && alarm && piiAddr == dio_edge_pkg::PII_EDGE && !anyEdge[0] |=> !edgeFlag_reg[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("edge flag survived its read");
    property p_lost;
        s_secondEdge |=> edgeLost_reg[0] && edgeFlag_reg[0];
    endproperty
    a_lost: assert property (p_lost) else $error("lost edge not flagged");
    property p_led;
        ##1 activityLed == $past(filt | outDrive_reg);
    endproperty
    a_led: assert property (p_led) else $error("activity lamp wrong");
    property p_err;
        |faultIn |=> errorLed;
    endproperty
    a_err: assert property (p_err) else $error("fault not shown on error lamp");
endmodule
`default_nettype wire

// ---- src/dio_edge_pkg.sv ----
// constants, types and decode helpers shared by the edge capture block
`default_nettype none
package dio_edge_pkg;
    localparam int CHANNELS       = 16;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int BASIC_DELAY_NS = 2560;
    localparam int ALARM_FIXED_NS = 1000;
    localparam int FILTER_UNIT_NS = 2560;
    localparam int TIMER_STEP_NS  = 1000;
    // least times, rounded up to whole cycles; the timer step is divided down without rounding
    localparam int BASIC_DELAY_CYC = (BASIC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALARM_FIXED_CYC = (ALARM_FIXED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_UNIT_CYC = (FILTER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_STEP_CYC  = TIMER_STEP_NS / CLK_PERIOD_NS;
    localparam logic [15:0] FILTER_MIN = 16'h0001;
    localparam logic [15:0] FILTER_MAX = 16'h3E80;
    localparam logic [6:0] BASIC_IN_BYTES    = 7'h02;
    localparam logic [6:0] ALARM_IN_BYTES    = 7'h30;
    localparam logic [6:0] OUT_BYTES         = 7'h02;
    localparam logic [6:0] ALARM_PARAM_BYTES = 7'h42;
    localparam logic [7:0] REC_DIAG   = 8'h7F;
    localparam logic [7:0] REC_SELECT = 8'h80;
    localparam logic [7:0] REC_FILTER = 8'h81;
    localparam logic [6:0] DIAG_WORD_HI = 7'h00;
    localparam logic [6:0] DIAG_WORD_LO = 7'h01;
    localparam logic [6:0] EDGE_SEL_LAST = 7'h0F;
    localparam logic [6:0] TS_SEL_LAST   = 7'h1F;
    localparam logic [6:0] FILTER_LAST   = 7'h1F;
    localparam logic [15:0] DIAG_ON = 16'h0001;
    localparam logic [5:0] PII_STATE  = 6'h00;
    localparam logic [5:0] PII_EDGE   = 6'h04;
    localparam logic [5:0] PII_LOST   = 6'h08;
    localparam logic [5:0] PII_TS     = 6'h0C;
    localparam logic [5:0] PII_TS_END = 6'h2B;
    typedef enum logic [1:0] {
        SEL_OFF  = 2'b00,
        SEL_RISE = 2'b01,
        SEL_FALL = 2'b10,
        SEL_BOTH = 2'b11
    } sel_t;
    typedef enum logic {
        MODE_BASIC = 1'b0,
        MODE_ALARM = 1'b1
    } mode_t;
    // bit 0 picks rising, bit 1 falling, so both bits give both edges
    function automatic logic selHit(input sel_t sel, input logic rise, input logic fall);
        return (rise && sel[0]) || (fall && sel[1]);
    endfunction
endpackage
`default_nettype wire

// ---- src/input_filter.sv ----
// per-channel input delay and stability filter
`default_nettype none
module input_filter #(
    parameter int UNIT_CYC  = dio_edge_pkg::FILTER_UNIT_CYC,
    parameter int BASIC_CYC = dio_edge_pkg::BASIC_DELAY_CYC,
    parameter int FIXED_CYC = dio_edge_pkg::ALARM_FIXED_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // sample and setup
    input  wire logic        sampleIn,
    input  wire logic        alarmMode,
    input  wire logic [15:0] filterUnits,
    // result
    output logic             filtered
);
    localparam logic [8:0] UNIT_LAST  = 9'(UNIT_CYC - 1);
    localparam logic [8:0] BASIC_LAST = 9'(BASIC_CYC - 1);
    localparam logic [8:0] FIXED_LAST = 9'(FIXED_CYC - 1);

    logic [8:0]  cyc_reg,  cyc_next;
    logic [15:0] unit_reg, unit_next;
    logic        done_reg, done_next;
    logic        filt_reg, filt_next;
    logic [15:0] need;
    logic [8:0]  fixedLast;

    always_comb begin
        need = 16'h0000;
        if (alarmMode) begin
            if (filterUnits < dio_edge_pkg::FILTER_MIN) need = dio_edge_pkg::FILTER_MIN;
            else if (filterUnits > dio_edge_pkg::FILTER_MAX) need = dio_edge_pkg::FILTER_MAX;
            else need = filterUnits;
        end
        fixedLast = alarmMode ? FIXED_LAST : BASIC_LAST;
        cyc_next  = cyc_reg;
        unit_next = unit_reg;
        done_next = done_reg;
        filt_next = filt_reg;
        // any bounce restarts the wait, so a level must hold the whole delay
        if (sampleIn == filt_reg) begin
            cyc_next  = 9'h000;
            unit_next = 16'h0000;
            done_next = 1'b0;
        end else if (!done_reg) begin
            if (cyc_reg == fixedLast) begin
                cyc_next = 9'h000;
                if (need == 16'h0000) filt_next = sampleIn;
                else done_next = 1'b1;
            end else begin
                cyc_next = cyc_reg + 9'h001;
            end
        end else if (cyc_reg == UNIT_LAST) begin
            cyc_next = 9'h000;
            if (unit_reg == need - 16'h0001) begin
                filt_next = sampleIn;
                done_next = 1'b0;
                unit_next = 16'h0000;
            end else begin
                unit_next = unit_reg + 16'h0001;
            end
        end else begin
            cyc_next = cyc_reg + 9'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cyc_reg  <= 9'h000;
            unit_reg <= 16'h0000;
            done_reg <= 1'b0;
            filt_reg <= 1'b0;
        end else begin
            cyc_reg  <= cyc_next;
            unit_reg <= unit_next;
            done_reg <= done_next;
            filt_reg <= filt_next;
        end
    end

    assign filtered = filt_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_filter_follows;
        !$stable(filt_reg) |-> filt_reg == $past(sampleIn) && $past(cyc_reg) == $past(fixedLast)
            || $past(done_reg);
    endproperty
    a_filter_follows: assert property (p_filter_follows) else $error("filter changed without full delay");
endmodule
`default_nettype wire

// ---- tb/cpu_model.sv ----
// controller model: loads the alarm mode, then boots the timebase
`default_nettype none
module cpu_model (
    // clock
    input  wire logic mclk,
    // request from the bench
    input  wire logic start,
    // configuration and timebase
    output logic      cfgLoad,
    output logic      cfgAlarm,
    output logic      ctrlBoot
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] step_reg = 2'h0;
    always @(posedge mclk) step_reg <= {step_reg[0], start};
    // mode is only meaningful with the load pulse, so both share one bit
    assign cfgLoad  = step_reg[0];
    assign cfgAlarm = step_reg[0];
    assign ctrlBoot = step_reg[1];
endmodule
`default_nettype wire

// ---- tb/test_dio16_edge_interrupt_timestamp.sv ----
// self-checking bench for the edge capture block
`default_nettype none
module test_dio16_edge_interrupt_timestamp;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 0, sys_rst = 1, start = 0, prmWrite = 0, piiRead = 0, piqWrite = 0, irqAck = 0;
    logic        cfgLoad, cfgAlarm, ctrlBoot, prmErr, piiReadErr, diagIrq, errorLed, alarmMode;
    logic        rd1 = 0, diagSeen = 0, piqAddr = 0;
    logic [15:0] tsExp;
    int          tick = 0;
    logic [7:0]  prmRecord = 8'h00, prmData = 8'h00, piiData, piqData = 8'h00, rnd;
    logic [6:0]  prmIndex = 7'h00;
    logic [5:0]  piiAddr = 6'h00;
    logic [3:0]  irqAckChannel = 4'h0;
    logic [15:0] inPins = 16'h0000, faultIn = 16'h0000, procIrq, outDrive, activityLed;
    logic [8:0]  expQ[$];
    int          fail_count = 0, cmp_count = 0, cyc = 0;
    always #5 mclk = ~mclk;
    cpu_model ctl (.mclk(mclk), .start(start), .cfgLoad(cfgLoad), .cfgAlarm(cfgAlarm), .ctrlBoot(ctrlBoot));
    dio16_edge_interrupt_timestamp uut (.mclk(mclk), .sys_rst(sys_rst), .cfgLoad(cfgLoad), .cfgAlarm(cfgAlarm),
        .ctrlBoot(ctrlBoot), .prmWrite(prmWrite), .prmRecord(prmRecord), .prmIndex(prmIndex), .prmData(prmData),
        .prmErr(prmErr), .piiRead(piiRead), .piiAddr(piiAddr), .piiData(piiData), .piiReadErr(piiReadErr),
        .piqWrite(piqWrite), .piqAddr(piqAddr), .piqData(piqData), .irqAck(irqAck), .irqAckChannel(irqAckChannel),
        .procIrq(procIrq), .diagIrq(diagIrq), .inPins(inPins), .faultIn(faultIn), .outDrive(outDrive),
        .activityLed(activityLed), .errorLed(errorLed), .alarmMode(alarmMode));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // the extra edge keeps a following request from rising in the same step
    task automatic wr(input logic [7:0] rec, input logic [6:0] idx, input logic [7:0] d, input logic err);
        prmRecord = rec;
        prmIndex = idx;
        prmData = d;
        prmWrite = 1;
        @(negedge mclk) prmWrite = 0;
        chk({15'h0, prmErr}, {15'h0, err});
        @(negedge mclk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [8:0] exp);
        piiAddr = a;
        piiRead = 1;
        expQ.push_back(exp);
        @(negedge mclk) piiRead = 0;
        @(negedge mclk);
    endtask
    always @(posedge mclk) rd1 <= piiRead;
    always @(negedge mclk) if (rd1) chk({7'h0, piiReadErr, piiData}, {7'h0, expQ.pop_front()});
    always @(posedge mclk) if (diagIrq === 1'b1) diagSeen <= 1;
    // cycles since the timebase was booted, to predict the stored microsecond count
    always @(posedge mclk) tick <= ctrlBoot ? 0 : tick + 1;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        void'($urandom(91920));
        repeat (5) @(negedge mclk);
        sys_rst = 0;
        @(negedge mclk);
        rd(6'h02, 9'h100);
        wr(8'h80, 7'h00, 8'h01, 1'b1);
        inPins[0] = 1;
        repeat (270) @(negedge mclk);
        rd(6'h00, 9'h001);
        inPins[0] = 0;
        repeat (270) @(negedge mclk);
        $display("basic mode test done");
        start = 1;
        @(negedge mclk) start = 0;
        repeat (3) @(negedge mclk);
        chk({15'h0, alarmMode}, 16'h0001);
        wr(8'h7F, 7'h00, 8'h00, 1'b0);
        wr(8'h7F, 7'h01, 8'h01, 1'b0);
        wr(8'h80, 7'h00, 8'hFD, 1'b0);
        wr(8'h80, 7'h10, 8'h03, 1'b0);
        wr(8'h80, 7'h20, 8'h00, 1'b1);
        rd(6'h30, 9'h100);
        inPins[0] = 1;
        for (int i = 0; i < 1000 && procIrq[0] !== 1'b1; i++) @(negedge mclk);
        chk(procIrq, 16'h0001);
        tsExp = 16'((tick - 1) / dio_edge_pkg::TIMER_STEP_CYC);
        rd(6'h0C, {1'b0, tsExp[15:8]});
        rd(6'h0D, {1'b0, tsExp[7:0]});
        rd(6'h04, 9'h001);
        rd(6'h04, 9'h000);
        inPins[0] = 0;
        repeat (400) @(negedge mclk);
        inPins[0] = 1;
        repeat (400) @(negedge mclk);
        chk({15'h0, diagSeen}, 16'h0001);
        rd(6'h08, 9'h001);
        irqAck = 1;
        @(negedge mclk) irqAck = 0;
        @(negedge mclk);
        chk(procIrq, 16'h0000);
        rnd = 8'($urandom);
        piqData = rnd;
        piqWrite = 1;
        faultIn[3] = 1;
        @(negedge mclk) begin
            piqAddr = 1;
            piqData = ~rnd;
        end
        @(negedge mclk) piqWrite = 0;
        repeat (3) @(negedge mclk);
        chk({8'h0, activityLed[7:0]}, {8'h0, rnd | 8'h01});
        chk(outDrive, {~rnd, rnd});
        chk({15'h0, errorLed}, 16'h0001);
        $display("alarm mode test done");
        results();
    end
endmodule
`default_nettype wire
